//--- tap_defs.svh
// constants for the boundary-scan test access port
//
// Overview of operation
// [R1] all serial inputs are sampled on the rising test clock edge
// [R2] all serial outputs, test data out included, change on the falling edge
// [R3] host steers the controller by mode select; an open mode select reads high
// [R4] exactly one scan register sits between data in and data out
// [R5] data enters at the msb and leaves from the lsb of every register
// [R6] port resets itself at power-up (here only from srst_i over test clock edges); data out drives only while shifting
// [R7] mode select high for five rising edges reaches test-logic-reset
// [R8] a port reset leaves memory operation undisturbed, allowed at any time
// [R9] instruction register is three bits, shifted while in the path
// [R10] instruction becomes the id instruction at power-up and in test-logic-reset
// [R11] capture-ir loads the two lowest instruction bits with 01
// [R12] bypass is one bit, single stage, cleared when bypass takes effect
// [R13] boundary register captures the pin ring and shifts in shift-dr
// [R14] ring capture happens for extest, sample/preload and sample-z
// [R15] with id instruction the id register captures its 32-bit code
// [R16] with the test clock held low the port stays in reset; here reset needs test clock edges, so a held-low clock never resets it
// [R17] a shifted instruction takes effect only in update-ir
// [R18] while sample-z is current the memory data outputs are high-z
// [R19] bypass instruction in shift-dr routes through the bypass bit
// [R20] standard sixteen-state controller, steered on each rising edge
`ifndef TAP_DEFS_SVH
`define TAP_DEFS_SVH

// --------------------------------------------------------------
// instruction register
// --------------------------------------------------------------
`define TAP_IR_W 3
`define TAP_IR_EXTEST 3'h0
`define TAP_IR_IDCODE 3'h1
`define TAP_IR_SAMPLEZ 3'h2
`define TAP_IR_SAMPLE 3'h4
`define TAP_IR_BYPASS 3'h7
`define TAP_IR_CAPT 3'h1

// --------------------------------------------------------------
// data registers
// --------------------------------------------------------------
`define TAP_ID_W 32
// arbitrary identification value
`define TAP_IDCODE 32'h1a5c_3001
`define TAP_BSR_W 90
`define TAP_OB_BIT 89

`endif

//--- tap_pkg.sv
// types for the boundary-scan test access port
package tap_pkg;

	// ----------------------------------------------------------
	// controller states, gray along the usual path
	// ----------------------------------------------------------
	typedef enum logic [3:0] {
		TS_TLR = 4'h0,
		TS_RTI = 4'h1,
		TS_SEL_DR = 4'h3,
		TS_CAP_DR = 4'h2,
		TS_SH_DR = 4'h6,
		TS_EX1_DR = 4'h7,
		TS_PAU_DR = 4'h5,
		TS_EX2_DR = 4'h4,
		TS_UPD_DR = 4'hc,
		TS_SEL_IR = 4'hd,
		TS_CAP_IR = 4'hf,
		TS_SH_IR = 4'he,
		TS_EX1_IR = 4'ha,
		TS_PAU_IR = 4'hb,
		TS_EX2_IR = 4'h9,
		TS_UPD_IR = 4'h8
	} tap_state_e;

	typedef logic [2:0] ir_t;

endpackage

//--- boundary_scan_tap.sv
// boundary-scan test access port of the memory
`timescale 1ns/1ps
`include "tap_defs.svh"

module boundary_scan_tap (
	// memory clock domain
	input wire logic mclk_i,
	input wire logic srst_i,
	// test port, link clock domain
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	// memory pin ring
	input wire logic [`TAP_BSR_W-1:0] ring_i,
	output logic dq_hiz_o
);

	// ----------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------
	function automatic logic sel_bsr(input tap_pkg::ir_t ir);
		sel_bsr = (ir == `TAP_IR_EXTEST) ||
			(ir == `TAP_IR_SAMPLE) ||
			(ir == `TAP_IR_SAMPLEZ);
	endfunction

	function automatic logic sel_id(input tap_pkg::ir_t ir);
		sel_id = (ir == `TAP_IR_IDCODE);
	endfunction

	// ----------------------------------------------------------
	// declarations
	// ----------------------------------------------------------
	tap_pkg::tap_state_e st_r;
	tap_pkg::tap_state_e st_nxt;
	logic rs_m_r;
	logic rs_s_r;
	logic tap_rst;
	logic [`TAP_BSR_W-1:0] ring_m_r;
	logic [`TAP_BSR_W-1:0] ring_s_r;
	tap_pkg::ir_t ir_sh_r;
	tap_pkg::ir_t ir_r;
	logic byp_r;
	logic [`TAP_ID_W-1:0] id_sh_r;
	logic [`TAP_BSR_W-1:0] bsr_sh_r;
	logic ob_en_r;
	logic hiz_lvl_r;
	logic shifting;
	logic tdo_nxt;
	logic hz_m_r;
	logic hz_s_r;

	// ----------------------------------------------------------
	// reset into the link domain
	// ----------------------------------------------------------
	// needs test clock edges; a stopped clock never resets the port,
	// while the memory side still resets from srst_i on its own
	always_ff @(posedge tck_i) begin
		rs_m_r <= srst_i;
		rs_s_r <= rs_m_r;
	end

	assign tap_rst = rs_s_r; // R6 R16

	// ----------------------------------------------------------
	// pin ring into the link domain
	// ----------------------------------------------------------
	// bits crossing independently; a moving pin may be caught
	// either way, as with any asynchronous sample
	always_ff @(posedge tck_i) begin
		ring_m_r <= ring_i;
		ring_s_r <= ring_m_r;
	end

	// ----------------------------------------------------------
	// controller
	// ----------------------------------------------------------
	always_comb begin
		st_nxt = tap_pkg::TS_TLR;
		case (st_r) // R20 R3
			tap_pkg::TS_TLR: begin
				st_nxt = tms_i ? tap_pkg::TS_TLR : tap_pkg::TS_RTI;
			end
			tap_pkg::TS_RTI: begin
				st_nxt = tms_i ? tap_pkg::TS_SEL_DR : tap_pkg::TS_RTI;
			end
			tap_pkg::TS_SEL_DR: begin
				st_nxt = tms_i ? tap_pkg::TS_SEL_IR : tap_pkg::TS_CAP_DR;
			end
			tap_pkg::TS_CAP_DR: begin
				st_nxt = tms_i ? tap_pkg::TS_EX1_DR : tap_pkg::TS_SH_DR;
			end
			tap_pkg::TS_SH_DR: begin
				st_nxt = tms_i ? tap_pkg::TS_EX1_DR : tap_pkg::TS_SH_DR;
			end
			tap_pkg::TS_EX1_DR: begin
				st_nxt = tms_i ? tap_pkg::TS_UPD_DR : tap_pkg::TS_PAU_DR;
			end
			tap_pkg::TS_PAU_DR: begin
				st_nxt = tms_i ? tap_pkg::TS_EX2_DR : tap_pkg::TS_PAU_DR;
			end
			tap_pkg::TS_EX2_DR: begin
				st_nxt = tms_i ? tap_pkg::TS_UPD_DR : tap_pkg::TS_SH_DR;
			end
			tap_pkg::TS_UPD_DR: begin
				st_nxt = tms_i ? tap_pkg::TS_SEL_DR : tap_pkg::TS_RTI;
			end
			tap_pkg::TS_SEL_IR: begin
				st_nxt = tms_i ? tap_pkg::TS_TLR : tap_pkg::TS_CAP_IR; // R7
			end
			tap_pkg::TS_CAP_IR: begin
				st_nxt = tms_i ? tap_pkg::TS_EX1_IR : tap_pkg::TS_SH_IR;
			end
			tap_pkg::TS_SH_IR: begin
				st_nxt = tms_i ? tap_pkg::TS_EX1_IR : tap_pkg::TS_SH_IR;
			end
			tap_pkg::TS_EX1_IR: begin
				st_nxt = tms_i ? tap_pkg::TS_UPD_IR : tap_pkg::TS_PAU_IR;
			end
			tap_pkg::TS_PAU_IR: begin
				st_nxt = tms_i ? tap_pkg::TS_EX2_IR : tap_pkg::TS_PAU_IR;
			end
			tap_pkg::TS_EX2_IR: begin
				st_nxt = tms_i ? tap_pkg::TS_UPD_IR : tap_pkg::TS_SH_IR;
			end
			tap_pkg::TS_UPD_IR: begin
				st_nxt = tms_i ? tap_pkg::TS_SEL_DR : tap_pkg::TS_RTI;
			end
			default: begin
				st_nxt = tap_pkg::TS_TLR;
			end
		endcase
	end

	always_ff @(posedge tck_i) begin // R1
		if (tap_rst) begin
			st_r <= tap_pkg::TS_TLR;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------
	// instruction register
	// ----------------------------------------------------------
	always_ff @(posedge tck_i) begin
		if (tap_rst) begin
			ir_sh_r <= `TAP_IR_IDCODE;
		end else if (st_r == tap_pkg::TS_CAP_IR) begin
			ir_sh_r <= `TAP_IR_CAPT; // R11
		end else if (st_r == tap_pkg::TS_SH_IR) begin
			ir_sh_r <= {tdi_i, ir_sh_r[2:1]}; // R9 R5
		end
	end

	// shadow keeps the running instruction stable while shifting
	always_ff @(posedge tck_i) begin
		if (tap_rst || st_r == tap_pkg::TS_TLR) begin
			ir_r <= `TAP_IR_IDCODE; // R10
		end else if (st_r == tap_pkg::TS_UPD_IR) begin
			ir_r <= ir_sh_r; // R17
		end
	end

	// ----------------------------------------------------------
	// bypass register
	// ----------------------------------------------------------
	// unused codes fall back to bypass so the chain never breaks
	always_ff @(posedge tck_i) begin
		if (tap_rst) begin
			byp_r <= 1'b0;
		end else if (st_r == tap_pkg::TS_UPD_IR && ir_sh_r == `TAP_IR_BYPASS) begin
			byp_r <= 1'b0; // R12
		end else if (st_r == tap_pkg::TS_CAP_DR && !sel_bsr(ir_r) && !sel_id(ir_r)) begin
			byp_r <= 1'b0; // R12
		end else if (st_r == tap_pkg::TS_SH_DR && !sel_bsr(ir_r) && !sel_id(ir_r)) begin
			byp_r <= tdi_i; // R19
		end
	end

	// ----------------------------------------------------------
	// identification register
	// ----------------------------------------------------------
	always_ff @(posedge tck_i) begin
		if (tap_rst) begin
			id_sh_r <= `TAP_IDCODE;
		end else if (st_r == tap_pkg::TS_CAP_DR && sel_id(ir_r)) begin
			id_sh_r <= `TAP_IDCODE; // R15
		end else if (st_r == tap_pkg::TS_SH_DR && sel_id(ir_r)) begin
			id_sh_r <= {tdi_i, id_sh_r[`TAP_ID_W-1:1]}; // R15 R5
		end
	end

	// ----------------------------------------------------------
	// boundary scan register
	// ----------------------------------------------------------
	always_ff @(posedge tck_i) begin
		if (tap_rst) begin
			bsr_sh_r <= '0;
		end else if (st_r == tap_pkg::TS_CAP_DR && sel_bsr(ir_r)) begin
			bsr_sh_r <= ring_s_r; // R13 R14
		end else if (st_r == tap_pkg::TS_SH_DR && sel_bsr(ir_r)) begin
			bsr_sh_r <= {tdi_i, bsr_sh_r[`TAP_BSR_W-1:1]}; // R13 R5
		end
	end

	// output-bus enable cell, preset high so extest drives by default
	always_ff @(posedge tck_i) begin
		if (tap_rst || st_r == tap_pkg::TS_TLR) begin
			ob_en_r <= 1'b1;
		end else if (st_r == tap_pkg::TS_UPD_DR && sel_bsr(ir_r)) begin
			ob_en_r <= bsr_sh_r[`TAP_OB_BIT];
		end
	end

	// level handed to the memory domain
	always_ff @(posedge tck_i) begin
		if (tap_rst) begin
			hiz_lvl_r <= 1'b0;
		end else begin
			hiz_lvl_r <= (ir_r == `TAP_IR_SAMPLEZ) ||
				(ir_r == `TAP_IR_EXTEST && !ob_en_r); // R18
		end
	end

	// ----------------------------------------------------------
	// serial output on the falling edge
	// ----------------------------------------------------------
	assign shifting = (st_r == tap_pkg::TS_SH_DR) || (st_r == tap_pkg::TS_SH_IR);

	always_comb begin
		tdo_nxt = byp_r;
		if (st_r == tap_pkg::TS_SH_IR) begin
			tdo_nxt = ir_sh_r[0]; // R4
		end else if (sel_bsr(ir_r)) begin
			tdo_nxt = bsr_sh_r[0]; // R4
		end else if (sel_id(ir_r)) begin
			tdo_nxt = id_sh_r[0]; // R4
		end
	end

	always_ff @(negedge tck_i) begin // R2
		if (tap_rst) begin
			tdo_o <= 1'b0;
			tdo_oe_o <= 1'b0; // R6
		end else begin
			tdo_o <= tdo_nxt;
			tdo_oe_o <= shifting; // R6
		end
	end

	// ----------------------------------------------------------
	// memory domain
	// ----------------------------------------------------------
	// only this level reaches the memory, so a port reset or any test
	// activity but sample-z, or extest with the enable cell low, leaves normal accesses alone
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			hz_m_r <= 1'b0;
			hz_s_r <= 1'b0;
			dq_hiz_o <= 1'b0;
		end else begin
			hz_m_r <= hiz_lvl_r;
			hz_s_r <= hz_m_r;
			dq_hiz_o <= hz_s_r; // R8 R18
		end
	end

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	// srst_i also gates the link checks: until the sync flops fill,
	// tap_rst itself is not yet known
	property p_tms_reset;
		@(posedge tck_i) disable iff (srst_i || tap_rst)
		tms_i [*5] |=> st_r == tap_pkg::TS_TLR;
	endproperty
	a_tms_reset: assert property (p_tms_reset) // R7
		else $error("five high mode-select edges did not reach reset");

	property p_ir_reset;
		@(posedge tck_i) disable iff (srst_i || tap_rst)
		st_r == tap_pkg::TS_TLR |=> ir_r == `TAP_IR_IDCODE;
	endproperty
	a_ir_reset: assert property (p_ir_reset) // R10
		else $error("instruction not id after test-logic-reset");

	property p_cap_ir;
		@(posedge tck_i) disable iff (srst_i || tap_rst)
		st_r == tap_pkg::TS_CAP_IR |=> ir_sh_r[1:0] == 2'h1;
	endproperty
	a_cap_ir: assert property (p_cap_ir) // R11
		else $error("capture-ir pattern wrong");

	property p_ir_shift;
		@(posedge tck_i) disable iff (srst_i || tap_rst)
		st_r == tap_pkg::TS_SH_IR |=>
			ir_sh_r == {$past(tdi_i), $past(ir_sh_r[2:1])};
	endproperty
	a_ir_shift: assert property (p_ir_shift) // R9
		else $error("instruction shift not toward lsb");

	property p_ir_update;
		@(posedge tck_i) disable iff (srst_i || tap_rst)
		!$stable(ir_r) |->
			$past(st_r) inside {tap_pkg::TS_UPD_IR, tap_pkg::TS_TLR};
	endproperty
	a_ir_update: assert property (p_ir_update) // R17
		else $error("instruction changed outside update-ir");

	property p_id_cap;
		@(posedge tck_i) disable iff (srst_i || tap_rst)
		st_r == tap_pkg::TS_CAP_DR && ir_r == `TAP_IR_IDCODE |=>
			id_sh_r == `TAP_IDCODE;
	endproperty
	a_id_cap: assert property (p_id_cap) // R15
		else $error("id register not captured");

	property p_byp_clear;
		@(posedge tck_i) disable iff (srst_i || tap_rst)
		st_r == tap_pkg::TS_CAP_DR && ir_r == `TAP_IR_BYPASS |=> !byp_r;
	endproperty
	a_byp_clear: assert property (p_byp_clear) // R12
		else $error("bypass bit not cleared");

	property p_oe_shift;
		@(posedge tck_i) disable iff (srst_i || tap_rst)
		tdo_oe_o == shifting;
	endproperty
	a_oe_shift: assert property (p_oe_shift) // R6
		else $error("data out enabled outside shifting");

	property p_byp_path;
		@(posedge tck_i) disable iff (srst_i || tap_rst)
		st_r == tap_pkg::TS_SH_DR && ir_r == `TAP_IR_BYPASS |->
			tdo_o == byp_r ##1 byp_r == $past(tdi_i);
	endproperty
	a_byp_path: assert property (p_byp_path) // R19
		else $error("bypass path broken");

	property p_sample_z;
		@(posedge mclk_i) disable iff (srst_i)
		$rose(hz_s_r) |=> dq_hiz_o;
	endproperty
	a_sample_z: assert property (p_sample_z) // R18
		else $error("memory outputs not released to high-z");

endmodule

//--- jtag_host_model.sv
// boundary-scan host model that steers the test port
`timescale 1ns/1ps
module jtag_host_model (
	// test port toward the device
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o,
	input wire logic tdo_i,
	input wire logic tdo_oe_i
);
	// a released line reads back inverted, so a stray sample shows up
	logic tdo_line;

	assign tdo_line = tdo_oe_i ? tdo_i : ~tdo_i;

	// ----------------------------------------------------------
	// clock rests low between frames, 80 ns period inside
	// ----------------------------------------------------------
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
	end

	task automatic cyc(input logic tms, input logic tdi, output logic tdo, output logic oe,
		output logic stab);
		logic t1;
		tms_o = tms;
		tdi_o = tdi;
		#40;
		t1 = tdo_line;
		oe = tdo_oe_i;
		tck_o = 1'b1;
		#39;
		// data out may move only at the fall
		stab = (t1 === tdo_line) || !oe;
		tdo = t1;
		#1;
		tck_o = 1'b0;
	endtask

	// ----------------------------------------------------------
	// five high mode-select edges, then idle
	// ----------------------------------------------------------
	task automatic tlr();
		logic a, b, c;
		repeat (5) cyc(1'b1, 1'b1, a, b, c);
		cyc(1'b0, 1'b1, a, b, c);
	endtask

	// from idle; n of 0 stops in pause-dr, or pause-ir when ir is set, instead of updating
	task automatic scan(input logic ir, input int n, input logic [89:0] din,
		output logic [89:0] dout, output logic oe_all, output logic stab_all);
		logic b, oe, st;
		dout = '0;
		oe_all = 1'b1;
		stab_all = 1'b1;
		cyc(1'b1, 1'b1, b, oe, st);
		if (ir) begin
			cyc(1'b1, 1'b1, b, oe, st);
		end
		cyc(1'b0, 1'b1, b, oe, st);
		cyc(1'b0, 1'b1, b, oe, st);
		for (int i = 0; i < n; i++) begin
			cyc(i == n - 1, din[i], b, oe, st);
			dout[i] = b;
			oe_all &= oe;
			stab_all &= st;
		end
		// update state is where a shifted instruction takes hold
		cyc(1'b1, 1'b1, b, oe, st);
		// extra idle edges let the memory side see the change
		repeat (3) cyc(1'b0, 1'b1, b, oe, st);
	endtask
endmodule

//--- boundary_scan_tap_tb.sv
// self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
`include "tap_defs.svh"
module boundary_scan_tap_tb;
	logic mclk_i;
	logic srst_i;
	logic tck_i;
	logic tms_i;
	logic tdi_i;
	logic tdo_o;
	logic tdo_oe_o;
	logic dq_hiz_o;
	logic [`TAP_BSR_W-1:0] ring_i;
	int fail_count;
	int checked;
	logic [2:0] cur_ir;
	logic ob_cell;
	logic [2:0] codes [6];

	// ----------------------------------------------------------
	// clock, device and host
	// ----------------------------------------------------------
	initial mclk_i = 1'b0;
	always #20 mclk_i = ~mclk_i;

	boundary_scan_tap dut (.mclk_i(mclk_i), .srst_i(srst_i), .tck_i(tck_i), .tms_i(tms_i),
		.tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .ring_i(ring_i), .dq_hiz_o(dq_hiz_o));
	jtag_host_model host (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o),
		.tdo_oe_i(tdo_oe_o));

	// ----------------------------------------------------------
	// compares and closing
	// ----------------------------------------------------------
	task automatic chk1(input logic got, input logic exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t %s: got %b want %b", $time, what, got, exp);
		end
	endtask

	task automatic chk_vec(input logic [89:0] got, input logic [89:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------
	// scans checked against expected register contents
	// ----------------------------------------------------------
	task automatic ir_load(input logic [2:0] code);
		logic [89:0] dout;
		logic oe, st;
		host.scan(1'b1, 3, 90'(code), dout, oe, st);
		chk_vec(dout, 90'(`TAP_IR_CAPT), "instruction capture");
		chk1(oe, 1'b1, "enable in shift-ir");
		cur_ir = code;
	endtask

	task automatic dr_check();
		logic [89:0] din, dout, exp;
		logic [95:0] r;
		logic oe, st;
		int n;
		r = {$urandom, $urandom, $urandom};
		din = r[89:0];
		// preload a floating output bus ahead of extest
		if (cur_ir == `TAP_IR_SAMPLE || cur_ir == `TAP_IR_EXTEST) begin
			din[`TAP_OB_BIT] = 1'b0;
		end
		case (cur_ir)
			// reserved codes fall back to the bypass bit
			`TAP_IR_BYPASS, 3'h3, 3'h5, 3'h6: begin
				n = 8;
				exp = 90'({din[6:0], 1'b0});
			end
			`TAP_IR_IDCODE: begin
				n = 32;
				exp = 90'(`TAP_IDCODE);
			end
			default: begin
				n = `TAP_BSR_W;
				exp = ring_i;
			end
		endcase
		host.scan(1'b0, n, din, dout, oe, st);
		chk_vec(dout, exp, "data register out");
		chk1(oe, 1'b1, "enable while shifting");
		chk1(st, 1'b1, "out steady across rise");
		chk1(tdo_oe_o, 1'b0, "enable after shift");
		if (n == `TAP_BSR_W) begin
			ob_cell = din[`TAP_OB_BIT];
		end
		repeat (10) @(posedge mclk_i);
		#1;
		chk1(dq_hiz_o, cur_ir == `TAP_IR_SAMPLEZ || (cur_ir == `TAP_IR_EXTEST && !ob_cell),
			"output float");
	endtask

	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		logic [95:0] r;
		logic [89:0] dout;
		logic oe, st;
		srst_i = 1'b1;
		ring_i = '0;
		fail_count = 0;
		checked = 0;
		cur_ir = `TAP_IR_IDCODE;
		ob_cell = 1'b1;
		codes = '{`TAP_IR_SAMPLE, `TAP_IR_EXTEST, `TAP_IR_SAMPLEZ, `TAP_IR_BYPASS, 3'h5,
			`TAP_IR_IDCODE};
		void'($urandom(32'h6dba));
		// tap reset needs test clock edges while reset is high
		fork
			begin
				repeat (8) @(posedge mclk_i);
				#1 srst_i = 1'b0;
			end
			host.tlr();
		join
		host.tlr();
		chk1(tdo_oe_o, 1'b0, "enable after reset");
		chk1(dq_hiz_o, 1'b0, "memory after reset");
		dr_check();
		foreach (codes[k]) begin
			@(posedge mclk_i);
			r = {$urandom, $urandom, $urandom};
			#1 ring_i = r[89:0];
			ir_load(codes[k]);
			dr_check();
		end
		// abort from pause-dr under bypass
		ir_load(`TAP_IR_BYPASS);
		host.scan(1'b0, 0, '0, dout, oe, st);
		host.tlr();
		cur_ir = `TAP_IR_IDCODE;
		ob_cell = 1'b1;
		chk1(tdo_oe_o, 1'b0, "enable after tap reset");
		chk1(dq_hiz_o, 1'b0, "memory after tap reset");
		dr_check();
		tally_and_finish();
	end

	initial begin
		#500000;
		fail_count++;
		$display("ERROR %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule
